// [rtl/adc_sequencing_control.sv]
// design: sequencing control for a 10-bit successive conversion unit
`timescale 1ns/1ps
`default_nettype none

module adc_sequencing_control #(
    parameter int RESULT_WIDTH = conv_seq_pkg::RESULT_WIDTH
) (
    input  wire logic                          mclk,         // 25 MHz clock
    input  wire logic                          sys_rst,      // sync reset, high
    input  wire conv_seq_pkg::ctrl_a_write_type ctrl_a,      // first control write
    input  wire logic                          ctrl_b_write, // second control write
    input  wire logic [2:0]                    ctrl_b_time,  // conversion-time code
    input  wire logic                          read_high,    // high result read strobe
    input  wire logic                          read_low,     // low result read strobe
    input  wire logic                          low_power_enter, // low-power entry pulse
    input  wire logic [RESULT_WIDTH-1:0]       sample_code,  // code from the analog core
    output var conv_seq_pkg::status_type       status,       // register view
    output logic [2:0]                         time_code,    // conversion-time field
    output logic                               conversion_done_irq, // one-cycle pulse
    output logic                               sample_enable, // analog core active
    output logic                               reference_disconnect // supply switch off
);

    // ************************************************************
    // elaboration check
    // ************************************************************
    if (RESULT_WIDTH != 10) begin : g_width_check
        $error("result width must be 10");
    end

    typedef enum logic [0:0] {ST_IDLE, ST_CONVERT} state_type;

    // ************************************************************
    // state
    // ************************************************************
    state_type                state_reg, state_next;
    logic [10:0]              count_reg, count_next;
    logic [2:0]               time_reg, time_next;
    logic [1:0]               mode_reg, mode_next;
    logic                     enable_reg, enable_next;
    logic [2:0]               chan_reg, chan_next;
    logic                     start_reg, start_next;
    logic                     eoc_reg, eoc_next;
    logic [9:0]               result_reg, result_next;
    logic                     irq_reg, irq_next;
    logic                     low_read_reg, low_read_next;
    logic                     refoff_reg, refoff_next;
    logic [10:0]              cycles;

    // ************************************************************
    // conversion time decode
    // ************************************************************
    always_comb begin
        case (time_reg)
            3'h0:    cycles = conv_seq_pkg::TIME_CYC_0;
            3'h1:    cycles = conv_seq_pkg::TIME_CYC_1;
            3'h2:    cycles = conv_seq_pkg::TIME_CYC_2;
            3'h3:    cycles = conv_seq_pkg::TIME_CYC_3;
            3'h4:    cycles = conv_seq_pkg::TIME_CYC_4;
            // reserved codes fall back to the slowest setting
            default: cycles = conv_seq_pkg::TIME_CYC_5;
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        state_next    = state_reg;
        count_next    = count_reg;
        time_next     = time_reg;
        mode_next     = mode_reg;
        enable_next   = enable_reg;
        chan_next     = chan_reg;
        start_next    = start_reg;
        eoc_next      = eoc_reg;
        result_next   = result_reg;
        irq_next      = 1'b0;
        low_read_next = low_read_reg;
        refoff_next   = refoff_reg;

        if (ctrl_b_write) begin
            time_next = ctrl_b_time;
        end
        if (read_low) begin
            low_read_next = 1'b1;
        end
        if (read_high) begin
            eoc_next      = 1'b0;
            low_read_next = 1'b0;
        end

        if (ctrl_a.write) begin
            chan_next   = ctrl_a.channel;
            enable_next = ctrl_a.input_enable;
            mode_next   = ctrl_a.mode;
            start_next  = ctrl_a.start;
            refoff_next = 1'b0;
        end

        case (state_reg)
            ST_IDLE: begin
                // launch only from a valid mode; start is dropped otherwise
                if (start_reg) begin
                    start_next = 1'b0;
                    if (mode_reg == conv_seq_pkg::MODE_SINGLE ||
                        mode_reg == conv_seq_pkg::MODE_REPEAT) begin
                        state_next = ST_CONVERT;
                        count_next = cycles;
                        eoc_next   = 1'b0;
                        // a fresh start forgets a half-read pair so its result lands
                        low_read_next = 1'b0;
                    end
                end
            end
            ST_CONVERT: begin
                if (count_reg > 11'd1) begin
                    count_next = count_reg - 11'd1;
                end else begin
                    // a half-read pair keeps the old value and drops the irq
                    if (!(low_read_reg && !read_high)) begin
                        result_next = sample_code;
                        eoc_next    = 1'b1;
                        irq_next    = 1'b1;
                    end
                    low_read_next = 1'b0;
                    if (mode_reg == conv_seq_pkg::MODE_REPEAT) begin
                        count_next = cycles;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase

        // abort outranks a completion landing in the same cycle
        if (ctrl_a.write && ctrl_a.mode == conv_seq_pkg::MODE_DISABLE) begin
            state_next  = ST_IDLE;
            low_read_next = 1'b0;
            start_next  = 1'b0;
            eoc_next    = 1'b0;
            result_next = conv_seq_pkg::RESULT_RESET;
            irq_next    = 1'b0;
        end

        // low-power entry outranks a same-cycle mode write
        if (low_power_enter) begin
            if (state_reg == ST_CONVERT) begin
                // supply stays cut until software rewrites the first register
                refoff_next = 1'b1;
            end
            state_next  = ST_IDLE;
            start_next  = 1'b0;
            mode_next   = conv_seq_pkg::MODE_RESET;
            enable_next = 1'b0;
            eoc_next    = 1'b0;
            result_next = conv_seq_pkg::RESULT_RESET;
            irq_next    = 1'b0;
            low_read_next = 1'b0;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg    <= ST_IDLE;
            count_reg    <= 11'h000;
            time_reg     <= 3'h0;
            mode_reg     <= conv_seq_pkg::MODE_RESET;
            enable_reg   <= 1'b0;
            chan_reg     <= 3'h0;
            start_reg    <= 1'b0;
            eoc_reg      <= 1'b0;
            result_reg   <= conv_seq_pkg::RESULT_RESET;
            irq_reg      <= 1'b0;
            low_read_reg <= 1'b0;
            refoff_reg   <= 1'b0;
        end else begin
            state_reg    <= state_next;
            count_reg    <= count_next;
            time_reg     <= time_next;
            mode_reg     <= mode_next;
            enable_reg   <= enable_next;
            chan_reg     <= chan_next;
            start_reg    <= start_next;
            eoc_reg      <= eoc_next;
            result_reg   <= result_next;
            irq_reg      <= irq_next;
            low_read_reg <= low_read_next;
            refoff_reg   <= refoff_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_comb begin
        status.end_of_conversion_flag = eoc_reg;
        status.converter_busy_flag    = (state_reg == ST_CONVERT);
        status.conversion_start_bit   = start_reg;
        status.operating_mode_field   = mode_reg;
        status.analog_input_enable    = enable_reg;
        status.input_channel_select   = chan_reg;
        status.result_low_byte        = result_reg[7:0];
        status.result_high_bits       = result_reg[9:8];
    end
    assign time_code            = time_reg;
    assign conversion_done_irq  = irq_reg;
    assign sample_enable        = (state_reg == ST_CONVERT);
    assign reference_disconnect = refoff_reg;

    // ************************************************************
    // assertions
    // ************************************************************
    abort_on_disable_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (ctrl_a.write && ctrl_a.mode == 2'h0) |=> !status.converter_busy_flag)
        else $error("mode disable did not stop conversion");
    disable_clears_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (ctrl_a.write && ctrl_a.mode == 2'h0 && !low_power_enter)
        |=> (!eoc_reg && result_reg == 10'h000))
        else $error("mode disable left flag or result");
    single_start_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (start_reg && !status.converter_busy_flag && mode_reg == 2'h1
         && !ctrl_a.write && !low_power_enter) |=> status.converter_busy_flag)
        else $error("single start did not begin");
    done_sets_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
        conversion_done_irq |-> (eoc_reg && $past(sample_code) == result_reg))
        else $error("irq without flag and result");
    high_read_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (read_high && !status.converter_busy_flag) |=> !eoc_reg)
        else $error("high read did not clear flag");
    restart_keeps_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ($rose(status.converter_busy_flag)) |-> (!eoc_reg && $stable(result_reg)))
        else $error("restart changed result or kept flag");
    low_power_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        low_power_enter |=> (mode_reg == 2'h0 && !enable_reg && !start_reg
                             && result_reg == 10'h000 && !eoc_reg))
        else $error("low power left state");
    low_power_halt_a: assert property (@(posedge mclk) disable iff (sys_rst)
        low_power_enter |=> (!status.converter_busy_flag)[*2])
        else $error("conversion kept running in low power");
    ref_switch_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (low_power_enter && status.converter_busy_flag) |=> reference_disconnect)
        else $error("reference not disconnected");
    start_self_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (status.converter_busy_flag && !ctrl_a.write) |=> !start_reg)
        else $error("start bit did not clear");
    fastest_time_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ($rose(status.converter_busy_flag) && time_reg == 3'h0 && mode_reg == 2'h1)
        |-> (count_reg == 11'd39))
        else $error("wrong conversion length");

    // software can rewrite mode or start while busy; the end and restart checks below exclude cycles with a first-register write or low-power entry
    single_end_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (status.converter_busy_flag && mode_reg == 2'h1 && count_reg == 11'd1
         && !ctrl_a.write && !low_power_enter) |=> !status.converter_busy_flag)
        else $error("single conversion did not end");
    repeat_restart_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (status.converter_busy_flag && mode_reg == 2'h3 && count_reg == 11'd1
         && !ctrl_a.write && !low_power_enter) |=> status.converter_busy_flag)
        else $error("repeat conversion did not restart");
    irq_one_cycle_a: assert property (@(posedge mclk) disable iff (sys_rst)
        conversion_done_irq |=> !conversion_done_irq)
        else $error("completion pulse longer than one cycle");
    abort_stays_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (ctrl_a.write && ctrl_a.mode == 2'h0) |=> (!status.converter_busy_flag)[*2])
        else $error("conversion resumed after abort");
    reserved_time_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ($rose(status.converter_busy_flag) && time_reg > 3'h5 && !$past(ctrl_b_write))
        |-> (count_reg == 11'd1248))
        else $error("reserved time code not slowest");
    launch_clears_start_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(status.converter_busy_flag) |-> !start_reg)
        else $error("start bit still set at launch");

    single_done_c: cover property (@(posedge mclk) disable iff (sys_rst)
        conversion_done_irq && mode_reg == 2'h1);
    repeat_done_c: cover property (@(posedge mclk) disable iff (sys_rst)
        conversion_done_irq && status.converter_busy_flag);
    forced_stop_c: cover property (@(posedge mclk) disable iff (sys_rst)
        status.converter_busy_flag && ctrl_a.write && ctrl_a.mode == 2'h0);
    low_power_c: cover property (@(posedge mclk) disable iff (sys_rst)
        status.converter_busy_flag && low_power_enter);
    half_read_c: cover property (@(posedge mclk) disable iff (sys_rst)
        status.converter_busy_flag && count_reg == 11'd1 && low_read_reg && !read_high);

endmodule : adc_sequencing_control

`default_nettype wire

// [rtl/conv_seq_pkg.sv]
// package: constants and carriers for the conversion sequencing control
package conv_seq_pkg;

    localparam int           RESULT_WIDTH   = 10;
    localparam int           CHAN_WIDTH     = 3;
    localparam int           TIME_CNT_WIDTH = 11;

    // operating_mode_field encodings
    localparam logic [1:0]   MODE_DISABLE   = 2'h0;
    localparam logic [1:0]   MODE_SINGLE    = 2'h1;
    localparam logic [1:0]   MODE_REPEAT    = 2'h3;

    // conversion-time codes and their cycle counts
    localparam logic [2:0]   TIME_CODE_MAX  = 3'h5;
    localparam logic [10:0]  TIME_CYC_0     = 11'd39;
    localparam logic [10:0]  TIME_CYC_1     = 11'd78;
    localparam logic [10:0]  TIME_CYC_2     = 11'd156;
    localparam logic [10:0]  TIME_CYC_3     = 11'd312;
    localparam logic [10:0]  TIME_CYC_4     = 11'd624;
    localparam logic [10:0]  TIME_CYC_5     = 11'd1248;

    // reset values
    localparam logic [9:0]   RESULT_RESET   = 10'h000;
    localparam logic [1:0]   MODE_RESET     = 2'h0;

    // software write into the first control register
    typedef struct packed {
        logic                  write;
        logic [CHAN_WIDTH-1:0] channel;
        logic                  input_enable;
        logic [1:0]            mode;
        logic                  start;
    } ctrl_a_write_type;

    // status seen by software
    typedef struct packed {
        logic                    end_of_conversion_flag;
        logic                    converter_busy_flag;
        logic                    conversion_start_bit;
        logic [1:0]              operating_mode_field;
        logic                    analog_input_enable;
        logic [CHAN_WIDTH-1:0]   input_channel_select;
        logic [7:0]              result_low_byte;
        logic [1:0]              result_high_bits;
    } status_type;

endpackage : conv_seq_pkg

// [test/analog_source_model.sv]
// model of the analog core feeding conversion codes to the block
`timescale 1ns/1ps
`default_nettype none

module analog_source_model (
    input  wire logic       mclk,          // system clock
    input  wire logic       sample_enable, // core active while converting
    input  wire logic [9:0] level,         // code that the sampled pin stands for
    output logic [9:0]      sample_code    // code toward the block
);
    logic [9:0] last_reg;

    // only the selected pin's level is modelled; no port traffic on shared pins
    always_ff @(posedge mclk) begin
        if (sample_enable) begin
            last_reg <= level;
        end
    end

    // idle core shows the inverse of its last code, so a stale sample cannot pass as good
    assign sample_code = sample_enable ? level : ~last_reg;
endmodule : analog_source_model

`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the conversion sequencing control
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic                           mclk;
    logic                           sys_rst;
    conv_seq_pkg::ctrl_a_write_type ctrl_a;
    logic                           ctrl_b_write;
    logic [2:0]                     ctrl_b_time;
    logic                           read_high;
    logic                           read_low;
    logic                           low_power_enter;
    logic [9:0]                     level;
    logic [9:0]                     sample_code;
    conv_seq_pkg::status_type       status;
    logic [2:0]                     time_code;
    logic                           conversion_done_irq;
    logic                           sample_enable;
    logic                           reference_disconnect;
    int                             errors;
    int                             compares;
    int                             cycles;
    int                             n;
    logic [10:0]                    cyc_tab [0:6];

    adc_sequencing_control dut_u (.mclk(mclk), .sys_rst(sys_rst), .ctrl_a(ctrl_a),
        .ctrl_b_write(ctrl_b_write), .ctrl_b_time(ctrl_b_time), .read_high(read_high),
        .read_low(read_low), .low_power_enter(low_power_enter), .sample_code(sample_code),
        .status(status), .time_code(time_code), .conversion_done_irq(conversion_done_irq),
        .sample_enable(sample_enable), .reference_disconnect(reference_disconnect));

    analog_source_model model_u (.mclk(mclk), .sample_enable(sample_enable), .level(level),
        .sample_code(sample_code));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 30000) begin
            errors = errors + 1;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_st(input conv_seq_pkg::status_type exp);
        compares = compares + 1;
        if (status !== exp) begin
            errors = errors + 1;
            $display("Error at %0t: status %h, expected %h", $time, status, exp);
        end
    endtask : chk_st

    task automatic wr_b(input logic [2:0] t);
        ctrl_b_time = t;
        ctrl_b_write = 1'b1;
        @(negedge mclk);
        ctrl_b_write = 1'b0;
    endtask : wr_b

    task automatic wr_a(input logic [1:0] mode, input logic st);
        ctrl_a.write = 1'b1;
        ctrl_a.channel = 3'h5;
        ctrl_a.input_enable = 1'b1;
        ctrl_a.mode = mode;
        ctrl_a.start = st;
        @(negedge mclk);
        ctrl_a = '0;
    endtask : wr_a

    // software order: channel, enable and mode, then the time field, then start
    task automatic setup(input logic [1:0] mode, input logic [2:0] t);
        wr_a(mode, 1'b0);
        wr_b(t);
    endtask : setup

    task automatic strobe(input int which);
        case (which)
            0: read_high = 1'b1;
            1: read_low = 1'b1;
            default: low_power_enter = 1'b1;
        endcase
        @(negedge mclk);
        case (which)
            0: read_high = 1'b0;
            1: read_low = 1'b0;
            default: low_power_enter = 1'b0;
        endcase
    endtask : strobe

    // cycles from busy rising, or from the last completion, to the next completion pulse
    task automatic measure(output int cnt);
        int k;
        k = 0;
        while (status.converter_busy_flag !== 1'b1 && k < 10) begin
            @(negedge mclk);
            k++;
        end
        cnt = 0;
        do begin
            @(negedge mclk);
            cnt++;
            if (cnt == 3) chk_val(16'(status.conversion_start_bit), 16'h0000);
        end while (conversion_done_irq !== 1'b1 && cnt < 1400);
    endtask : measure

    task automatic no_activity(input int len);
        int hits;
        hits = 0;
        repeat (len) begin
            @(negedge mclk);
            if (conversion_done_irq !== 1'b0 || status.converter_busy_flag !== 1'b0) hits++;
        end
        chk_val(16'(hits), 16'h0000);
    endtask : no_activity

    task automatic test_single_times();
        for (int t = 0; t < 7; t++) begin
            level = 10'h2a5 ^ 10'(t);
            setup(conv_seq_pkg::MODE_SINGLE, 3'(t));
            chk_val(16'(time_code), 16'(t));
            wr_a(conv_seq_pkg::MODE_SINGLE, 1'b1);
            measure(n);
            chk_val(16'(n), 16'(cyc_tab[t]));
            chk_val(16'(status.end_of_conversion_flag), 16'h0001);
            chk_val(16'(status.converter_busy_flag), 16'h0000);
            chk_val({status.result_high_bits, status.result_low_byte}, 16'(level));
            strobe(1);
            chk_val(16'(conversion_done_irq), 16'h0000);
            strobe(0);
            chk_val(16'(status.end_of_conversion_flag), 16'h0000);
        end
    endtask : test_single_times

    task automatic test_restart_unread();
        level = 10'h13c;
        setup(conv_seq_pkg::MODE_SINGLE, 3'h0);
        wr_a(conv_seq_pkg::MODE_SINGLE, 1'b1);
        measure(n);
        level = 10'h0c3;
        wr_a(conv_seq_pkg::MODE_SINGLE, 1'b1);
        repeat (3) @(negedge mclk);
        chk_val(16'(status.end_of_conversion_flag), 16'h0000);
        chk_val({status.result_high_bits, status.result_low_byte}, 16'h013c);
        measure(n);
        chk_val({status.result_high_bits, status.result_low_byte}, 16'h00c3);
    endtask : test_restart_unread

    task automatic test_repeat_stop();
        conv_seq_pkg::status_type exp;
        int hits;
        level = 10'h3ff;
        setup(conv_seq_pkg::MODE_REPEAT, 3'h0);
        wr_a(conv_seq_pkg::MODE_REPEAT, 1'b1);
        measure(n);
        measure(n);
        chk_val(16'(n), 16'(conv_seq_pkg::TIME_CYC_0));
        chk_val(16'(status.converter_busy_flag), 16'h0001);
        // completion between low and high reads keeps the old code and drops the pulse
        level = 10'h155;
        strobe(1);
        hits = 0;
        repeat (45) begin
            @(negedge mclk);
            if (conversion_done_irq !== 1'b0) hits++;
        end
        chk_val(16'(hits), 16'h0000);
        chk_val({status.result_high_bits, status.result_low_byte}, 16'h03ff);
        repeat (10) @(negedge mclk);
        wr_a(conv_seq_pkg::MODE_DISABLE, 1'b0);
        @(negedge mclk);
        exp = '0;
        exp.analog_input_enable = 1'b1;
        exp.input_channel_select = 3'h5;
        chk_st(exp);
        chk_val({status.end_of_conversion_flag, status.converter_busy_flag,
                 status.result_high_bits, status.result_low_byte}, 16'h0000);
        no_activity(60);
    endtask : test_repeat_stop

    task automatic test_low_power();
        conv_seq_pkg::status_type exp;
        setup(conv_seq_pkg::MODE_SINGLE, 3'h0);
        wr_a(conv_seq_pkg::MODE_SINGLE, 1'b1);
        repeat (5) @(negedge mclk);
        strobe(2);
        exp = '0;
        exp.input_channel_select = 3'h5;
        chk_st(exp);
        chk_val(16'(reference_disconnect), 16'h0001);
        no_activity(60);
        wr_a(2'h2, 1'b1);
        chk_val(16'(reference_disconnect), 16'h0000);
        no_activity(60);
    endtask : test_low_power

    initial begin
        errors = 0;
        compares = 0;
        cycles = 0;
        cyc_tab = '{conv_seq_pkg::TIME_CYC_0, conv_seq_pkg::TIME_CYC_1, conv_seq_pkg::TIME_CYC_2,
                    conv_seq_pkg::TIME_CYC_3, conv_seq_pkg::TIME_CYC_4, conv_seq_pkg::TIME_CYC_5,
                    conv_seq_pkg::TIME_CYC_5};
        ctrl_a = '0;
        ctrl_b_write = 1'b0;
        ctrl_b_time = 3'h0;
        read_high = 1'b0;
        read_low = 1'b0;
        low_power_enter = 1'b0;
        level = 10'h000;
        sys_rst = 1'b1;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        test_single_times();
        test_restart_unread();
        test_repeat_stop();
        test_low_power();
        end_sim();
    end
endmodule : testbench

`default_nettype wire
